// >>> rtl/eerd_pkg.sv
/*
 * constants and types for the two-wire serial memory read engine.
 * assumes an 11-bit array address (8 blocks of 256 bytes), a bus
 * master that drives the serial clock, and a 4-word trace buffer.
 */
package eerd_pkg;

	// ==========================================================
	// array geometry
	localparam int unsigned ADDR_W     = 11;        // whole array
	localparam int unsigned DATA_W     = 8;         // one byte
	localparam int unsigned BLK_W      = 3;         // block select bits
	localparam int unsigned TYPE_W     = 4;         // device type code
	localparam int unsigned MEM_DEPTH  = 2048;      // bytes in the array
	localparam logic [7:0]  MEM_INIT   = 8'hff;     // content before any write

	// ==========================================================
	// select byte layout: type[7:4], block[3:1], direction[0]
	localparam int unsigned SEL_TYPE_LSB = 4;
	localparam int unsigned SEL_BLK_LSB  = 1;
	localparam int unsigned SEL_RW_BIT   = 0;
	localparam logic        RW_READ      = 1'b1;
	localparam logic        RW_WRITE     = 1'b0;

	// ==========================================================
	// bit slot counting on the serial clock
	localparam logic [3:0] BIT_LAST  = 4'h7;        // eighth data bit
	localparam logic [3:0] BIT_ACK   = 4'h8;        // ninth, acknowledge slot
	localparam logic [3:0] BIT_FIRST = 4'h0;
	// data bits already sampled when the start notice arrives
	localparam logic [3:0] START_LAG = 4'h3;

	// ==========================================================
	// trace buffer shape
	localparam int unsigned FIFO_DEPTH = 4;

	// ==========================================================
	// link states, gray along idle -> select -> address -> read
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEL  = 2'b01,
		ST_ADDR = 2'b11,
		ST_READ = 2'b10
	} eerd_state_t;

endpackage

// >>> rtl/eerd_engine.sv
/*
 * read engine of a 16 kbit two-wire serial memory, plus its trace fifo.
 * assumes the serial clock arrives on i_scl_clk as a clock of its own,
 * that data settles while that clock is low, and that the start hold
 * time exceeds three reference clock periods.
 */
// What this block does
// - reads ignore any write mode selection
// - array starts with every byte at ffh
// - address counter advances once per byte read
// - current read: ack select, send byte, increment
// - dummy write loads address, stores nothing
// - repeated start read returns loaded address byte
// - acked bytes keep streaming next address
// - counter wraps from top to bottom
// - ninth bit high means stop, go standby
// - select byte: type, block, direction
// - byte address picks one of 256 bytes
// - stop after read forces standby
// - sender releases data for acknowledge slot
`timescale 1ns/1ps

// ==========================================================
// shift-register fifo, head entry is a flop
module eerd_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// filling side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// draining side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	logic [WIDTH-1:0] data_q [0:DEPTH-1];   // entry 0 is the head
	logic [DEPTH-1:0] vld_q;                // one valid bit per entry
	logic             pop;                  // head leaves this cycle
	logic             push;                 // new word accepted
	logic [DEPTH-1:0] vld_above;            // bit i: entry i+1 holds a word
	logic [DEPTH-1:0] vld_below;            // bit i: entry i-1 holds a word, head always

	// neighbour views keep every index in range at both ends
	assign vld_above   = {1'b0, vld_q[DEPTH-1:1]};
	assign vld_below   = {vld_q[DEPTH-2:0], 1'b1};
	assign pop         = vld_q[0] & i_out_ready;
	assign push        = i_in_valid & o_in_ready;
	// ready only from the last slot, so full is honest
	assign o_in_ready  = ~vld_q[DEPTH-1];
	assign o_out_valid = vld_q[0];
	assign o_out_data  = data_q[0];

	// entries shift toward the head on a pop; push lands at the tail
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			vld_q <= '0;
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (pop) begin
					// next entry moves down, or the new word fills the hole
					if (vld_above[i]) begin
						vld_q[i]  <= 1'b1;
						data_q[i] <= data_q[(i + 1) % DEPTH];
					end else if (push && (i == 0 || vld_q[i])) begin
						vld_q[i]  <= 1'b1;
						data_q[i] <= i_in_data;
					end else begin
						vld_q[i] <= 1'b0;
					end
				end else if (push && !vld_q[i] && vld_below[i]) begin
					// first free slot takes the word
					vld_q[i]  <= 1'b1;
					data_q[i] <= i_in_data;
				end
			end
		end
	end
endmodule

// ==========================================================
// top: link logic on the serial clock, array and trace on the reference
module eerd_engine
	import eerd_pkg::*;
#(
	// device type code, value is arbitrary and must match the bus master
	parameter logic [TYPE_W-1:0] DEV_TYPE = 4'h5
) (
	// reference clock domain
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	// serial link
	input  wire logic              i_scl_clk,
	input  wire logic              i_sda,
	output logic                   o_sda_out,
	output logic                   o_sda_oe_n,
	// array load port from the write path
	input  wire logic              i_wr_valid,
	input  wire logic [ADDR_W-1:0] i_wr_addr,
	input  wire logic [DATA_W-1:0] i_wr_data,
	// trace of bytes sent on the bus
	output logic                   o_trace_valid,
	output logic      [DATA_W-1:0] o_trace_data,
	input  wire logic              i_trace_ready,
	output logic                   o_trace_full,
	output logic                   o_trace_drop
);

	// ==========================================================
	// storage array
	// power-up content before any write; the write process stays the only driver
	logic [DATA_W-1:0] mem_q [0:MEM_DEPTH-1] = '{default: MEM_INIT};

	// write path loads bytes; a write to the byte being read is a hazard
	always_ff @(posedge i_ref_clk) begin
		if (i_wr_valid) begin
			mem_q[i_wr_addr] <= i_wr_data;
		end
	end

	// ==========================================================
	// reference domain: start and stop detection
	logic scl_s1_q, scl_s2_q, scl_s3_q;    // serial clock synchroniser
	logic sda_s1_q, sda_s2_q, sda_s3_q;    // serial data synchroniser
	logic start_tog_q;                     // flips on each start
	logic stop_tog_q;                      // flips on each stop
	logic bus_start;                       // data falls while clock high
	logic bus_stop;                        // data rises while clock high

	// two flops per pin, third stage only for edge history
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
			{sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
		end else begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= {i_scl_clk, scl_s1_q, scl_s2_q};
			{sda_s1_q, sda_s2_q, sda_s3_q} <= {i_sda, sda_s1_q, sda_s2_q};
		end
	end

	assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

	// events leave as toggles; the serial side cannot see pulses
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			start_tog_q <= 1'b0;
			stop_tog_q  <= 1'b0;
		end else begin
			start_tog_q <= start_tog_q ^ bus_start;
			stop_tog_q  <= stop_tog_q ^ bus_stop;
		end
	end

	// ==========================================================
	// serial domain: reset and event synchronisers
	logic rst_l1_q, rst_l2_q;              // reset into serial domain
	logic start_l1_q, start_l2_q;          // start toggle synchroniser
	logic stop_l1_q, stop_l2_q;            // stop toggle synchroniser
	logic start_seen_q, stop_seen_q;       // last toggle values acted on
	logic link_start;                      // start reached this edge
	logic link_stop;                       // stop reached this edge

	// only moves while the master clocks; idle time holds state
	always_ff @(posedge i_scl_clk) begin
		rst_l1_q   <= i_rst;
		rst_l2_q   <= rst_l1_q;
		start_l1_q <= start_tog_q;
		start_l2_q <= start_l1_q;
		stop_l1_q  <= stop_tog_q;
		stop_l2_q  <= stop_l1_q;
	end

	assign link_start = start_l2_q ^ start_seen_q;
	assign link_stop  = stop_l2_q ^ stop_seen_q;

	// ==========================================================
	// serial domain: bit engine on the rising edge
	eerd_state_t       state_q;            // link state
	logic [3:0]        bit_q;              // slot of the next rising edge
	logic [DATA_W-1:0] rx_q;               // bits sampled so far
	logic [DATA_W-1:0] rx_byte;            // byte completed this edge
	logic [DATA_W-1:0] tx_q;               // byte being sent
	logic [ADDR_W-1:0] addr_q;             // internal byte address counter
	logic [BLK_W-1:0]  blk_q;              // block of latest write select
	logic              ack_q;              // we drive the next ninth bit
	logic [DATA_W-1:0] trace_q;            // last byte put on the bus
	logic              trace_tog_q;        // flips per byte sent

	assign rx_byte = {rx_q[DATA_W-2:0], i_sda};

	// data sampled on the rising edge is stable by the protocol itself
	always_ff @(posedge i_scl_clk) begin
		rx_q <= rx_byte;
	end

	// slot counter, realigned by the late start notice
	always_ff @(posedge i_scl_clk) begin
		if (rst_l2_q) begin
			bit_q <= BIT_FIRST;
		end else if (link_start) begin
			bit_q <= START_LAG;
		end else if (bit_q == BIT_ACK) begin
			bit_q <= BIT_FIRST;
		end else begin
			bit_q <= bit_q + 4'h1;
		end
	end

	// protocol state, counter and byte fetch
	always_ff @(posedge i_scl_clk) begin
		if (rst_l2_q) begin
			state_q      <= ST_IDLE;
			ack_q        <= 1'b0;
			addr_q       <= '0;
			blk_q        <= '0;
			tx_q         <= MEM_INIT;
			trace_q      <= MEM_INIT;
			trace_tog_q  <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q  <= 1'b0;
		end else begin
			start_seen_q <= start_l2_q;
			stop_seen_q  <= stop_l2_q;
			if (link_start) begin
				// any start, repeated or not, begins a select byte
				state_q <= ST_SEL;
				ack_q   <= 1'b0;
			end else if (link_stop) begin
				state_q <= ST_IDLE;
				ack_q   <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						ack_q <= 1'b0;
					end
					ST_SEL: begin
						if (bit_q == BIT_LAST) begin
							// type code, block bits, direction; no mode input
							if (rx_byte[DATA_W-1:SEL_TYPE_LSB] == DEV_TYPE) begin
								ack_q <= 1'b1;
								if (rx_byte[SEL_RW_BIT] == RW_WRITE) begin
									// dummy write: keep block, expect address
									blk_q <= rx_byte[SEL_BLK_LSB +: BLK_W];
								end
							end else begin
								state_q <= ST_IDLE;
							end
						end else if (bit_q == BIT_ACK && ack_q) begin
							ack_q <= 1'b0;
							if (rx_q[0] == RW_READ) begin
								// send the byte at the counter, then advance
								state_q     <= ST_READ;
								tx_q        <= mem_q[addr_q];
								trace_q     <= mem_q[addr_q];
								trace_tog_q <= ~trace_tog_q;
								addr_q      <= addr_q + 11'h001;
							end else begin
								state_q <= ST_ADDR;
							end
						end
					end
					ST_ADDR: begin
						if (bit_q == BIT_LAST) begin
							// load counter only, nothing is stored
							addr_q <= {blk_q, rx_byte};
							ack_q  <= 1'b1;
						end else if (bit_q == BIT_ACK) begin
							// data bytes belong to the write path
							ack_q   <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
					ST_READ: begin
						if (bit_q == BIT_ACK) begin
							if (i_sda == 1'b0) begin
								// top address rolls over to zero by width
								tx_q        <= mem_q[addr_q];
								trace_q     <= mem_q[addr_q];
								trace_tog_q <= ~trace_tog_q;
								addr_q      <= addr_q + 11'h001;
							end else begin
								// no acknowledge: end transfer, standby
								state_q <= ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// serial domain: data driver on the falling edge
	logic sda_out_q;                       // level driven when enabled
	logic sda_oe_n_q = 1'b1;               // released at power-up

	// ack is driven low in slot nine; data bits in slots one to eight
	always_ff @(negedge i_scl_clk) begin
		if (rst_l2_q) begin
			sda_out_q  <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else if (ack_q && bit_q == BIT_ACK && !link_start) begin
			sda_out_q  <= 1'b0;
			sda_oe_n_q <= 1'b0;
		end else if (state_q == ST_READ && bit_q != BIT_ACK) begin
			sda_out_q  <= tx_q[BIT_LAST[2:0] - bit_q[2:0]];
			sda_oe_n_q <= 1'b0;
		end else begin
			// release after eight bits so the master can answer
			sda_out_q  <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end
	end

	assign o_sda_out  = sda_out_q;
	assign o_sda_oe_n = sda_oe_n_q;

	// ==========================================================
	// reference domain: trace capture into the fifo
	logic              trc_s1_q, trc_s2_q, trc_s3_q;  // byte toggle sync
	logic              trc_push;                       // new byte seen
	logic              fifo_ready;                     // room in fifo
	logic              drop_q;                         // byte lost, full
	logic              full_q;                         // registered full

	// trace byte is stable for nine serial periods, far beyond sync delay
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			{trc_s1_q, trc_s2_q, trc_s3_q} <= 3'h0;
		end else begin
			{trc_s1_q, trc_s2_q, trc_s3_q} <= {trace_tog_q, trc_s1_q, trc_s2_q};
		end
	end

	assign trc_push = trc_s2_q ^ trc_s3_q;

	eerd_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_trace_fifo (
		.i_clk       (i_ref_clk),
		.i_rst       (i_rst),
		.i_in_valid  (trc_push),
		.i_in_data   (trace_q),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_trace_valid),
		.o_out_data  (o_trace_data),
		.i_out_ready (i_trace_ready)
	);

	// bus cannot be stalled, so a full fifo loses the byte and says so
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			drop_q <= 1'b0;
			full_q <= 1'b0;
		end else begin
			drop_q <= trc_push & ~fifo_ready;
			full_q <= ~fifo_ready;
		end
	end

	assign o_trace_full = full_q;
	assign o_trace_drop = drop_q;

endmodule

// >>> verification/eerd_engine_asserts.sv
/* port checker of the read engine.
   assumes a bind from the bench top onto eerd_engine. */
`timescale 1ns/1ps
// ==========================================================
// checker
module eerd_engine_asserts (
	// clocks and reset
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_scl_clk,
	// serial wire
	input wire logic       i_sda,
	input wire logic       o_sda_out,
	input wire logic       o_sda_oe_n,
	// trace side
	input wire logic       o_trace_valid,
	input wire logic [7:0] o_trace_data,
	input wire logic       i_trace_ready,
	input wire logic       o_trace_full,
	input wire logic       o_trace_drop
);
	// first drive after a released byte is the acknowledge
	chk_ack_is_low: assert property (
		@(posedge i_scl_clk) disable iff (i_rst)
		o_sda_oe_n [*8] ##1 !o_sda_oe_n |-> !o_sda_out) else $error("ack not low");
	// ack plus eight data bits, then the wire is let go
	chk_byte_release: assert property (
		@(posedge i_scl_clk) disable iff (i_rst)
		o_sda_oe_n ##1 !o_sda_oe_n [*8] ##1 !o_sda_oe_n |=> o_sda_oe_n)
		else $error("data held past byte");
	// high ninth bit after a sent byte: stay off the wire
	chk_nack_standby: assert property (
		@(posedge i_scl_clk) disable iff (i_rst)
		!$past(o_sda_oe_n) && o_sda_oe_n && i_sda |=> o_sda_oe_n [*7])
		else $error("drives after nack");
	// overflow flag is a single cycle
	chk_drop_pulse: assert property (
		@(posedge i_ref_clk) disable iff (i_rst) o_trace_drop |=> !o_trace_drop)
		else $error("drop too long");
	// a byte is only lost when the buffer is full
	chk_drop_full: assert property (
		@(posedge i_ref_clk) disable iff (i_rst) o_trace_drop |-> o_trace_full)
		else $error("drop while not full");
	// a stalled head keeps its byte
	chk_head_holds: assert property (
		@(posedge i_ref_clk) disable iff (i_rst) o_trace_valid && !i_trace_ready
		|=> o_trace_valid && $stable(o_trace_data)) else $error("head lost");
	// full implies something at the head
	chk_full_head: assert property (
		@(posedge i_ref_clk) disable iff (i_rst) o_trace_full |-> o_trace_valid)
		else $error("full but empty");
	// trace side silent while reset is held
	chk_reset_quiet: assert property (
		@(posedge i_ref_clk) i_rst ##1 i_rst |-> !o_trace_valid && !o_trace_drop)
		else $error("trace active in reset");
	// main scenarios
	cov_drop: cover property (@(posedge i_ref_clk) o_trace_drop);
	cov_full: cover property (@(posedge i_ref_clk) o_trace_full);
	cov_ack: cover property (@(posedge i_scl_clk) !o_sda_oe_n && !o_sda_out);
endmodule

// >>> verification/eerd_master.sv
/* behavioural two-wire bus master issuing reads.
   assumes a pull-up on data; the clock stands high between frames. */
`timescale 1ns/1ps
// ==========================================================
// master model
module eerd_master
	import eerd_pkg::*;
#(
	parameter logic [3:0] TYPE_CODE = 4'h5 // arbitrary, must match the engine
) (
	// engine drive
	input  wire logic i_oe_n,
	input  wire logic i_out,
	// wire levels
	output logic      o_scl,
	output wire logic o_sda
);
	logic sda_m = 1'b1; // own drive, 1 = released
	initial o_scl = 1'b1;
	// open drain: either side pulls low, pull-up otherwise
	// short hold: the wire never moves in the same instant as the clock
	assign #2 o_sda = sda_m & ~(~i_oe_n & ~i_out);
	// one slot: data set while low, sampled at the rise
	task automatic slot(input logic b, output logic r);
		#20 sda_m = b;
		#42.5 o_scl = 1'b1;
		r = o_sda;
		#62.5 o_scl = 1'b0;
	endtask
	// bare clocks, only used around reset so the link side can settle
	task automatic idle(input int n);
		repeat (n) begin
			#62.5 o_scl = 1'b0;
			#62.5 o_scl = 1'b1;
		end
	endtask
	// start or repeated start: data falls under a high clock
	task automatic start();
		#15 sda_m = 1'b1;
		#16 o_scl = 1'b1;
		#31 sda_m = 1'b0;
		#62 o_scl = 1'b0;
	endtask
	// stop: data rises under a high clock, clock then stands
	task automatic stop();
		#15 sda_m = 1'b0;
		#16 o_scl = 1'b1;
		#31 sda_m = 1'b1;
	endtask
	// byte out msb first, then let go for the acknowledge
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			slot(b[i], r);
		slot(1'b1, r);
		ack = ~r;
	endtask
	// byte in, then low to go on or high to finish
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			slot(1'b1, d[i]);
		slot(~ack, r);
	endtask
	// select byte: type, block, direction
	task automatic sel(input logic [2:0] blk, input logic rw, output logic ack);
		put({TYPE_CODE, blk, rw}, ack);
	endtask
	// dummy write of the address, then a read select, same upper seven
	// bits in both
	task automatic rand_addr(input logic [2:0] blk, input logic [7:0] a, output logic ack);
		logic k0, k1, k2;
		start();
		sel(blk, RW_WRITE, k0);
		put(a, k1);
		start();
		sel(blk, RW_READ, k2);
		ack = k0 & k1 & k2;
	endtask
endmodule

// >>> verification/tb.sv
/* self-checking bench of the read engine.
   assumes eerd_master on the wire and the checker bound below. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
// ==========================================================
// bench top
module tb;
	import eerd_pkg::*;
	localparam logic [3:0] TC   = 4'h5;  // arbitrary type code
	localparam int         CEIL = 20000; // ref cycles before a hang is cut
	logic        i_ref_clk = 1'b0;
	logic        i_rst     = 1'b1;
	logic        scl, sda, sda_out, oe_n, t_valid, t_full, t_drop;
	logic        wr_v      = 1'b0;
	logic [10:0] wr_a      = 11'h000;
	logic [7:0]  wr_d      = 8'h00;
	logic [7:0]  t_data;
	logic        t_ready   = 1'b1;
	logic        ack;
	logic [7:0]  d;
	int          mismatches = 0, n_tests = 0, cyc = 0, drops = 0;
	eerd_engine #(.DEV_TYPE(TC)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_scl_clk(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n),
		.i_wr_valid(wr_v), .i_wr_addr(wr_a), .i_wr_data(wr_d), .o_trace_valid(t_valid),
		.o_trace_data(t_data), .i_trace_ready(t_ready), .o_trace_full(t_full),
		.o_trace_drop(t_drop));
	eerd_master #(.TYPE_CODE(TC)) u_m (.i_oe_n(oe_n), .i_out(sda_out), .o_scl(scl), .o_sda(sda));
	initial forever #10 i_ref_clk = ~i_ref_clk;
	// hang guard and overflow count
	always @(posedge i_ref_clk) begin
		cyc++;
		if (t_drop === 1'b1)
			drops++;
		if (cyc == CEIL) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// array load through the write port
	task automatic put_mem(input logic [10:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		wr_v <= 1'b1;
		wr_a <= a;
		wr_d <= v;
		@(posedge i_ref_clk);
		wr_v <= 1'b0;
	endtask
	task automatic t_blank();
		u_m.rand_addr(3'h1, 8'h23, ack);
		`CHK(ack, 1'b1)
		u_m.get(1'b0, d);
		`CHK(d, MEM_INIT)
		u_m.stop();
	endtask
	// stream across the top of the array
	task automatic t_wrap();
		for (int i = 0; i < 4; i++)
			put_mem(11'h7fe + 11'(i), 8'ha0 + 8'(i));
		put_mem(11'h002, 8'he5);
		put_mem(11'h202, 8'h3c);
		u_m.rand_addr(3'h7, 8'hfe, ack);
		`CHK(ack, 1'b1)
		for (int i = 0; i < 4; i++) begin
			u_m.get(i < 3, d);
			`CHK(d, 8'ha0 + 8'(i))
		end
		u_m.stop();
	endtask
	// read select block bits must not steer the counter
	task automatic t_current();
		u_m.start();
		u_m.sel(3'h2, RW_READ, ack);
		`CHK(ack, 1'b1)
		u_m.get(1'b0, d);
		`CHK(d, 8'he5)
		u_m.stop();
	endtask
	task automatic t_badtype();
		u_m.start();
		u_m.put({~TC, 3'h0, RW_READ}, ack);
		`CHK(ack, 1'b0)
		u_m.stop();
	endtask
	// clocking on after a nack without stop: wire must stay released
	task automatic t_nack();
		put_mem(11'h010, 8'h5a);
		u_m.rand_addr(3'h0, 8'h10, ack);
		u_m.get(1'b0, d);
		`CHK(d, 8'h5a)
		u_m.get(1'b0, d);
		`CHK(d, 8'hff)
		u_m.stop();
	endtask
	// six bytes into a stalled four word trace, then drain
	task automatic t_fifo();
		for (int i = 0; i < 6; i++)
			put_mem(11'h020 + 11'(i), 8'h61 + 8'(i));
		@(posedge i_ref_clk);
		t_ready <= 1'b0;
		drops = 0;
		u_m.rand_addr(3'h0, 8'h20, ack);
		for (int i = 0; i < 6; i++)
			u_m.get(i < 5, d);
		u_m.stop();
		repeat (8) @(posedge i_ref_clk);
		#1;
		`CHK(t_full, 1'b1)
		`CHK(drops, 2)
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 8 && t_valid !== 1'b1; k++) begin
				@(posedge i_ref_clk);
				#1;
			end
			`CHK(t_data, 8'h61 + 8'(i))
			@(posedge i_ref_clk);
			t_ready <= 1'b1;
			@(posedge i_ref_clk);
			t_ready <= 1'b0;
			#1;
		end
		`CHK(t_valid, 1'b0)
	endtask
	initial begin
		// link side needs clock edges to leave reset
		fork
			u_m.idle(3);
			repeat (16) @(posedge i_ref_clk);
		join
		@(posedge i_ref_clk);
		i_rst <= 1'b0;
		u_m.idle(3);
		t_blank();
		t_wrap();
		t_current();
		t_badtype();
		t_nack();
		t_fifo();
		stop_test();
	end
endmodule
bind eerd_engine eerd_engine_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_scl_clk(i_scl_clk), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
	.o_trace_valid(o_trace_valid), .o_trace_data(o_trace_data),
	.i_trace_ready(i_trace_ready), .o_trace_full(o_trace_full), .o_trace_drop(o_trace_drop));
